//--- logic/trr_pkg.sv
// constants for the temperature result register pair
package trr_pkg;
  localparam int          TRR_CODE_W    = 12;
  localparam int          TRR_BYTE_W    = 8;
  localparam logic [7:0]  TRR_ADDR_LOW  = 8'h0E;
  localparam logic [7:0]  TRR_ADDR_HIGH = 8'h0F;
  localparam logic [11:0] TRR_CODE_RST  = 12'h000;
  localparam logic [7:0]  TRR_RD_UNMAP  = 8'h00;
  // low byte flag positions
  localparam int          TRR_BIT_FAIL  = 3;
  localparam int          TRR_BIT_BUSY  = 2;
  localparam int          TRR_BIT_INT   = 1;
  localparam int          TRR_BIT_BACK  = 0;
  // split of the code over the two bytes
  localparam int          TRR_FRAC_W    = 4;
  localparam int          TRR_FRAC_LSB  = 4;
endpackage

//--- logic/trr_code_reg.sv
// holder for the 12-bit temperature code, loaded on the update tick
`timescale 1ns/1ps
module trr_code_reg
  import trr_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  loadPulse,
  input  wire logic [TRR_CODE_W-1:0] loadCode,
  output logic      [TRR_CODE_W-1:0] codeOut
);
  logic [TRR_CODE_W-1:0] code_q;

  // direct update, no shadow copy behind it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      code_q <= TRR_CODE_RST;
    end else if (loadPulse) begin
      code_q <= loadCode;
    end
  end

  assign codeOut = code_q;
endmodule

//--- logic/trr_regs.sv
// temperature result registers: low byte with flags and high byte
`timescale 1ns/1ps
// Summary of operation
// - 12-bit two's-complement code, one sixteenth degree per unit.
// - high byte holds sign and integer bits, code bits 11 to 4.
// - low byte holds fraction bits 7..4, then four flags in bits 3..0.
// - code reads zero after reset until the first result loads.
// - both bytes update directly on the tick; no shadow copy.
module trr_regs
  import trr_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  tickPulse,
  input  wire logic [TRR_CODE_W-1:0] measCode,
  input  wire logic                  eepromFailSet,
  input  wire logic                  eepromBusy,
  input  wire logic                  clockOutIntSet,
  input  wire logic                  backupSwitchSet,
  input  wire logic [7:0]            regAddr,
  input  wire logic                  regWrite,
  input  wire logic [TRR_BYTE_W-1:0] regWdata,
  input  wire logic                  regRead,
  output logic      [TRR_BYTE_W-1:0] regRdata,
  output logic                       regRvalid,
  output logic                       eepromFailFlag,
  output logic                       clockOutIntFlag,
  output logic                       backupSwitchFlag
);
  logic [TRR_CODE_W-1:0] codeNow;
  logic                  eepromFailFlag_q;
  logic                  clockOutIntFlag_q;
  logic                  backupSwitchFlag_q;
  logic [TRR_BYTE_W-1:0] rdata_q;
  logic                  rvalid_q;
  logic                  writeLow;
  logic                  tickSeen_q;

  // every check in this module runs on the system clock, idle in reset
  default clocking trrCb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // one flag: hardware set wins over a host write of zero
  function automatic logic flagNext(input logic cur, input logic setEv,
                                    input logic wr, input logic wbit);
    if (setEv) begin
      flagNext = 1'b1;
    end else if (wr && !wbit) begin
      flagNext = 1'b0;
    end else begin
      flagNext = cur;
    end
  endfunction

  // assemble the low byte from fraction bits and flags
  function automatic logic [TRR_BYTE_W-1:0] lowByte(
    input logic [TRR_CODE_W-1:0] c, input logic f3, input logic f2,
    input logic f1, input logic f0);
    lowByte = {c[TRR_FRAC_W-1:0], f3, f2, f1, f0};
  endfunction

  // the code register, fed straight from the measurement
  trr_code_reg uCode (
    .clock     (clock),
    .rstn      (rstn),
    .loadPulse (tickPulse),
    .loadCode  (measCode),
    .codeOut   (codeNow)
  );

  assign writeLow = regWrite && (regAddr == TRR_ADDR_LOW);

  // the code follows each tick at once and rests between ticks; there is
  // no shadow copy, so a host may see bytes of two results
  sequence s_tick_load;
    tickPulse ##1 (codeNow == $past(measCode));
  endsequence

  a_code_load_tick: assert property (
    tickPulse |-> s_tick_load)
    else $error("code not loaded on tick");

  a_code_holds_idle: assert property (
    !tickPulse |=> $stable(codeNow))
    else $error("code changed without tick");

  a_reset_code_zero: assert property (
    !tickSeen_q |-> (codeNow == TRR_CODE_RST))
    else $error("code not zero before first result");

  a_frac_write_safe: assert property (
    writeLow && !tickPulse |=> codeNow == $past(codeNow))
    else $error("write disturbed fraction bits");

  a_high_read_only: assert property (
    regWrite && (regAddr == TRR_ADDR_HIGH) && !tickPulse
      |=> $stable(codeNow))
    else $error("write reached the high byte");

  // sticky flags; writes to the low byte touch only these
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      eepromFailFlag_q   <= 1'b0;
      clockOutIntFlag_q  <= 1'b0;
      backupSwitchFlag_q <= 1'b0;
    end else begin
      eepromFailFlag_q   <= flagNext(eepromFailFlag_q, eepromFailSet,
                              writeLow, regWdata[TRR_BIT_FAIL]);
      clockOutIntFlag_q  <= flagNext(clockOutIntFlag_q, clockOutIntSet,
                              writeLow, regWdata[TRR_BIT_INT]);
      backupSwitchFlag_q <= flagNext(backupSwitchFlag_q, backupSwitchSet,
                              writeLow, regWdata[TRR_BIT_BACK]);
    end
  end

  // hardware set wins over a clearing write; a written one keeps the flag
  a_flag_set_wins: assert property (
    clockOutIntSet && writeLow && !regWdata[TRR_BIT_INT]
      |=> clockOutIntFlag_q)
    else $error("flag set lost to clear");

  a_flag_clear_write: assert property (
    writeLow && !regWdata[TRR_BIT_FAIL] && !eepromFailSet
      |=> !eepromFailFlag_q)
    else $error("flag not cleared by write");

  a_flag_write_one: assert property (
    writeLow && regWdata[TRR_BIT_BACK] && backupSwitchFlag_q
      |=> backupSwitchFlag_q)
    else $error("flag lost on a written one");

  a_flag_set_sticky: assert property (
    eepromFailSet |=> eepromFailFlag_q)
    else $error("flag not set by its event");

  // registered read data; unmapped addresses read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= TRR_RD_UNMAP;
    end else if (regRead) begin
      case (regAddr)
        TRR_ADDR_LOW:  rdata_q <= lowByte(codeNow, eepromFailFlag_q,
                                  eepromBusy, clockOutIntFlag_q,
                                  backupSwitchFlag_q);
        TRR_ADDR_HIGH: rdata_q <=
                         codeNow[TRR_CODE_W-1:TRR_FRAC_LSB];
        default:       rdata_q <= TRR_RD_UNMAP;
      endcase
    end
  end

  // read answers: the high byte is code bits 11..4 with the sign on top,
  // the low byte puts the fraction above the four flag bits
  sequence s_read_high;
    regRead && (regAddr == TRR_ADDR_HIGH) ##1 regRvalid;
  endsequence

  sequence s_read_low;
    regRead && (regAddr == TRR_ADDR_LOW) ##1 regRvalid;
  endsequence

  a_high_byte_map: assert property (
    s_read_high |->
      regRdata == $past(codeNow[TRR_CODE_W-1:TRR_FRAC_LSB]))
    else $error("high byte does not match code");

  a_sign_in_high: assert property (
    s_read_high |->
      regRdata[TRR_BYTE_W-1] == $past(codeNow[TRR_CODE_W-1]))
    else $error("sign bit not on top of high byte");

  a_low_frac_map: assert property (
    regRead && (regAddr == TRR_ADDR_LOW) |=> regRvalid
      && (regRdata[TRR_BYTE_W-1:TRR_FRAC_LSB]
          == $past(codeNow[TRR_FRAC_W-1:0]))
      && (regRdata[TRR_BIT_BUSY] == $past(eepromBusy))
      && (regRdata[TRR_BIT_BACK] == $past(backupSwitchFlag_q)))
    else $error("low byte layout wrong");

  a_low_flag_map: assert property (
    s_read_low |->
      (regRdata[TRR_BIT_FAIL] == $past(eepromFailFlag_q))
      && (regRdata[TRR_BIT_INT] == $past(clockOutIntFlag_q)))
    else $error("low byte flags wrong");

  a_unmap_read_zero: assert property (
    regRead && (regAddr != TRR_ADDR_LOW) && (regAddr != TRR_ADDR_HIGH)
      |=> regRdata == TRR_RD_UNMAP)
    else $error("unmapped read not zero");

  // read answer strobe, one cycle after the request
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= regRead;
    end
  end

  // the read answer lasts exactly one cycle per request
  a_read_answer: assert property (
    regRead |=> regRvalid)
    else $error("read got no answer");

  a_rvalid_single: assert property (
    !regRead |=> !regRvalid)
    else $error("answer without a read");

  // helper for checking: has any result been loaded yet
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tickSeen_q <= 1'b0;
    end else if (tickPulse) begin
      tickSeen_q <= 1'b1;
    end
  end

  assign regRdata         = rdata_q;
  assign regRvalid        = rvalid_q;
  assign eepromFailFlag   = eepromFailFlag_q;
  assign clockOutIntFlag  = clockOutIntFlag_q;
  assign backupSwitchFlag = backupSwitchFlag_q;

endmodule

//--- verif/trr_host_model.sv
// host side model driving the internal register port
`timescale 1ns/1ps
module trr_host_model (
  input  wire logic       clock,
  input  wire logic       regRvalid,
  input  wire logic [7:0] regRdata,
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic      [7:0] regWdata,
  output logic            regRead
);
  // idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWdata = 8'h00;
    regRead = 1'b0;
  end
  // one strobe cycle, then a bounded wait; address scrambled after release
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    d = 8'h00;
    ok = 1'b0;
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clock);
      ok = (regRvalid === 1'b1);
      d = regRdata;
    end
  endtask
  // one write strobe, data scrambled after release
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clock);
    regAddr <= a;
    regWdata <= w;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regWdata <= ~w;
  endtask
  // code read twice; accepted only when both readings agree
  task automatic rdcode(output logic [11:0] c, output bit ok);
    logic [7:0] h[2];
    logic [7:0] l[2];
    bit k[4];
    for (int i = 0; i < 2; i++) begin
      rd(8'h0F, h[i], k[2*i]);
      rd(8'h0E, l[i], k[2*i+1]);
    end
    c = {h[0], l[0][7:4]};
    ok = k[0] && k[1] && k[2] && k[3]
      && h[0] === h[1] && l[0] === l[1];
  endtask
endmodule

//--- verif/trr_regs_tb_top.sv
// testbench for the temperature result registers
`timescale 1ns/1ps
module trr_regs_tb_top;
  import trr_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, tickPulse = 1'b0, eepromBusy = 1'b0;
  logic failSet = 1'b0, clkSet = 1'b0, bswSet = 1'b0;
  logic [11:0] measCode = 12'h000;
  wire logic [7:0] regAddr, regWdata, regRdata;
  wire logic regWrite, regRead, regRvalid, fFail, fClk, fBsw;
  int error_cnt = 0, compares = 0;
  always #10 clock = ~clock;
  trr_regs i_dut (.clock(clock), .rstn(rstn), .tickPulse(tickPulse),
    .measCode(measCode), .eepromFailSet(failSet), .eepromBusy(eepromBusy),
    .clockOutIntSet(clkSet), .backupSwitchSet(bswSet), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead),
    .regRdata(regRdata), .regRvalid(regRvalid), .eepromFailFlag(fFail),
    .clockOutIntFlag(fClk), .backupSwitchFlag(fBsw));
  trr_host_model i_host (.clock(clock), .regRvalid(regRvalid),
    .regRdata(regRdata), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRead(regRead));
  task automatic chk(input string n, input logic [11:0] s,
                     input logic [11:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // read a register and return its byte, ending the run on no answer
  function automatic void lost(bit ok);
    if (!ok) error_cnt++;
  endfunction
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bit ok;
    i_host.rd(a, d, ok);
    lost(ok);
    if (!ok) wrap_up();
  endtask
  // load one measurement on a one-cycle tick
  task automatic tick(input logic [11:0] c);
    @(posedge clock);
    tickPulse <= 1'b1;
    measCode <= c;
    @(posedge clock);
    tickPulse <= 1'b0;
  endtask
  task automatic s_codes;
    logic [11:0] t[5] = '{12'h7FF, 12'h800, 12'hFFF, 12'h010, 12'hD80};
    int deg[5] = '{127, -128, -1, 1, -40};
    logic [11:0] c;
    logic [7:0] d;
    bit ok;
    foreach (t[i]) begin
      tick(t[i]);
      i_host.rdcode(c, ok);
      chk("codeok", {11'h000, ok}, 12'h001);
      chk("code", c, t[i]);
      rd(TRR_ADDR_HIGH, d);
      chk("high", {4'h0, d}, {4'h0, t[i][11:4]});
      chk("degrees", 12'($signed(d)), 12'(deg[i]));
    end
  endtask
  task automatic s_write_flags;
    logic [7:0] d;
    tick(12'h5A3);
    @(posedge clock);
    {failSet, clkSet, bswSet, eepromBusy} <= 4'hF;
    @(posedge clock);
    {failSet, clkSet, bswSet} <= 3'h0;
    i_host.wr(TRR_ADDR_LOW, 8'hFF);
    chk("flagset", {9'h000, fFail, fClk, fBsw}, 12'h007);
    rd(TRR_ADDR_LOW, d);
    chk("low", {4'h0, d}, 12'h03F);
    i_host.wr(TRR_ADDR_LOW, 8'h00);
    i_host.wr(TRR_ADDR_HIGH, 8'h00);
    rd(TRR_ADDR_LOW, d);
    chk("lowclr", {1'b0, fFail, fClk, fBsw, d}, 12'h034);
    // set event and clearing write taken at the same edge
    fork
      i_host.wr(TRR_ADDR_LOW, 8'h00);
      begin
        @(posedge clock);
        clkSet <= 1'b1;
        @(posedge clock);
        clkSet <= 1'b0;
      end
    join
    @(posedge clock);
    chk("setwins", {11'h000, fClk}, 12'h001);
    rd(TRR_ADDR_HIGH, d);
    chk("highro", {4'h0, d}, 12'h05A);
    rd(8'h10, d);
    chk("unmap", {4'h0, d}, {4'h0, TRR_RD_UNMAP});
    eepromBusy <= 1'b0;
  endtask
  // bytes read across a tick come from two results
  task automatic s_straddle;
    logic [7:0] h;
    logic [7:0] l;
    tick(12'h100);
    rd(TRR_ADDR_HIGH, h);
    tick(12'h2F7);
    rd(TRR_ADDR_LOW, l);
    chk("mix", {h, l[7:4]}, 12'h107);
  endtask
  // a reset in mid-run clears the code and the flags again
  task automatic s_mid_reset;
    logic [7:0] d;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(TRR_ADDR_HIGH, d);
    chk("rsthigh2", {4'h0, d}, 12'h000);
    chk("rstflags", {9'h000, fFail, fClk, fBsw}, 12'h000);
  endtask
  initial begin
    logic [7:0] d;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    rd(TRR_ADDR_HIGH, d);
    chk("rsthigh", {4'h0, d}, 12'h000);
    rd(TRR_ADDR_LOW, d);
    chk("rstlow", {4'h0, d}, 12'h000);
    s_codes();
    s_write_flags();
    s_straddle();
    s_mid_reset();
    wrap_up();
  end
endmodule
